// ---- verilog/sard_defs.svh ----
// constants of the shift and add register datapath
`ifndef SARD_DEFS_SVH
`define SARD_DEFS_SVH

// word width and bit positions, index 0 is the sign at the left
`define SARD_WIDTH      40
`define SARD_SIGN_BIT   0
`define SARD_LSB_BIT    39

// reset values
`define SARD_RST_WORD   40'h00_0000_0000
`define SARD_RST_EXT    1'h0

`endif

// ---- verilog/sard_pkg.sv ----
// types shared by the shift and add register datapath
`include "sard_defs.svh"
`default_nettype none

package sard_pkg;

  // which operand gate feeds the adder's second input
  typedef enum logic [2:0] {
    sard_sel_none  = 3'b001,
    sard_sel_true  = 3'b010,
    sard_sel_compl = 3'b100
  } sard_sel_t;

  typedef logic [0:`SARD_WIDTH-1] sard_word_t;

  // the whole state of the datapath
  typedef struct packed {
    logic       acc_ext;
    sard_word_t acc_stg;
    sard_word_t acc_main;
    sard_word_t quot_stg;
    sard_word_t quot_main;
    sard_word_t operand;
    sard_sel_t  add_sel;
  } sard_state_t;

endpackage : sard_pkg

`default_nettype wire

// ---- verilog/sard_xfer.sv ----
// clear-then-gate next value of one flip-flop register
`default_nettype none

module sard_xfer #(
  parameter int WIDTH = 40
) (
  input  wire logic [0:WIDTH-1] cur_in,
  input  wire logic             clr_zero_in,
  input  wire logic             clr_one_in,
  input  wire logic             set_en_in,
  input  wire logic [0:WIDTH-1] set_src_in,
  input  wire logic             rst_en_in,
  input  wire logic [0:WIDTH-1] rst_src_in,
  output logic      [0:WIDTH-1] nxt_out
);

  // gates only ever push bits away from the cleared value, so a
  // transfer is exact when the clear came in an earlier step or in the same step
  always_comb begin
    nxt_out = cur_in;
    if (clr_zero_in) begin
      nxt_out = '0;
    end
    if (clr_one_in) begin
      nxt_out = '1;
    end
    if (set_en_in) begin
      nxt_out = nxt_out | set_src_in;
    end
    if (rst_en_in) begin
      nxt_out = nxt_out & rst_src_in;
    end
  end

endmodule : sard_xfer

`default_nettype wire

// ---- verilog/sard_adder.sv ----
// parallel adder with a carry into the rightmost stage
`default_nettype none

module sard_adder #(
  parameter int WIDTH = 40
) (
  input  wire logic [0:WIDTH-1] a_in,
  input  wire logic [0:WIDTH-1] b_in,
  input  wire logic             cin_in,
  output logic      [0:WIDTH-1] sum_out
);

  logic [0:WIDTH] full;

  // carry out of the sign stage is dropped: two's complement wrap
  always_comb begin
    full    = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, cin_in};
    sum_out = full[1:WIDTH];
  end

endmodule : sard_adder

`default_nettype wire

// ---- verilog/sard_datapath.sv ----
// accumulator, quotient and operand registers with shift and add paths
`include "sard_defs.svh"
`default_nettype none

// How it works
// (RQ1) every word register is forty flip-flops wide, accumulator staging one more
// (RQ2) each main register shifts only through its own staging register
// (RQ3) transfers clear the target first, then gate only the differing bits
// (RQ4) right shift: staging to zeros, ones up, main to ones, zeros down
// (RQ5) the staging extra bit gates into the main sign on a right move
// (RQ6) left shift uses the same steps with left-displaced final gates
// (RQ7) bit 0 is the sign at the left, bit 39 the rightmost
// (RQ8) the quotient pair shifts together with the accumulator pair
// (RQ9) left shift: accumulator top bit enters quotient bit 39, quotient top lost
// (RQ10) left shift moves the accumulator sign like any other bit
// (RQ11) right shift: accumulator low bit enters the quotient sign position
// (RQ12) right shift replicates the accumulator sign into vacated bits
// (RQ13) adder first input is always the accumulator main register
// (RQ14) add loads memory into operand, gate 2 presents its true value
// (RQ15) accumulator staging clears while the sum forms
// (RQ16) gate 3 loads the sum left-displaced, gate 4 moves it right
// (RQ17) staging has an extra bit left of its sign feeding the main sign
// (RQ18) subtract presents inverted operand with a carry into bit 39
// (RQ19) control gives one pulse per step, two at add step 3, and never conflicting gates
// (RQ20) quotient pulses come from the same steps as the accumulator's
module sard_datapath (
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire sard_pkg::sard_word_t mem_word_in,
  input  wire logic              clr_operand_in,
  input  wire logic              load_operand_in,
  input  wire logic              gate_true_in,
  input  wire logic              gate_compl_in,
  input  wire logic              clr_stg_zero_in,
  input  wire logic              copy_up_in,
  input  wire logic              clr_main_one_in,
  input  wire logic              shift_right_in,
  input  wire logic              shift_left_in,
  input  wire logic              gate_sum_in,
  input  wire logic              sum_right_in,
  output logic                   acc_staging_sign_ext_out,
  output sard_pkg::sard_word_t   acc_staging_out,
  output sard_pkg::sard_word_t   acc_main_out,
  output sard_pkg::sard_word_t   quot_staging_out,
  output sard_pkg::sard_word_t   quot_main_out,
  output sard_pkg::sard_word_t   operand_reg_out,
  output sard_pkg::sard_sel_t    adder_sel_out
);
  import sard_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sard_state_t state_reg; // RQ1 RQ7
  sard_state_t state_next;

  sard_word_t adder_b;
  logic       adder_cin;
  sard_word_t adder_sum;

  logic [0:`SARD_WIDTH] acc_stg_set_src;
  logic [0:`SARD_WIDTH] acc_stg_nxt;
  sard_word_t acc_main_rst_src;
  sard_word_t acc_main_nxt;
  sard_word_t quot_main_rst_src;
  sard_word_t quot_main_nxt;
  sard_word_t quot_stg_nxt;
  sard_word_t operand_nxt;
  logic       acc_down;
  logic       quot_down;

  // ----------------------------------------------------------------
  // adder
  // ----------------------------------------------------------------
  // the accumulator main register is wired to the adder at all times
  always_comb begin
    adder_b   = '0;
    adder_cin = 1'b0;
    unique case (state_reg.add_sel)
      sard_sel_none: begin
        adder_b   = '0;
        adder_cin = 1'b0;
      end
      sard_sel_true: begin
        adder_b   = state_reg.operand; // RQ14
        adder_cin = 1'b0;
      end
      sard_sel_compl: begin
        adder_b   = ~state_reg.operand; // RQ18
        adder_cin = 1'b1; // RQ18
      end
    endcase
  end

  sard_adder #(
    .WIDTH (`SARD_WIDTH)
  ) u_adder (
    .a_in    (state_reg.acc_main), // RQ13
    .b_in    (adder_b),
    .cin_in  (adder_cin),
    .sum_out (adder_sum)
  );

  // ----------------------------------------------------------------
  // transfer sources
  // ----------------------------------------------------------------
  always_comb begin
    // ones into staging: main copied up with its sign into the extra
    // bit, or the sum displaced one place left (RQ16, RQ17)
    acc_stg_set_src = '0;
    if (copy_up_in) begin
      acc_stg_set_src = {state_reg.acc_main[`SARD_SIGN_BIT],
                         state_reg.acc_main}; // RQ2 RQ4
    end
    if (gate_sum_in) begin
      acc_stg_set_src = {adder_sum, 1'b0}; // RQ16 RQ17
    end
    // zeros down into main; the extra bit feeds the sign so the sign
    // replicates on a right shift and the sum sign lands after an add
    acc_down         = shift_right_in | shift_left_in | sum_right_in;
    acc_main_rst_src = '1;
    if (shift_right_in || sum_right_in) begin
      acc_main_rst_src = {state_reg.acc_ext,
                          state_reg.acc_stg[0:`SARD_LSB_BIT-1]}; // RQ5 RQ12
    end
    if (shift_left_in) begin
      acc_main_rst_src = {state_reg.acc_stg[1:`SARD_LSB_BIT],
                          1'b0}; // RQ6 RQ10
    end
    // quotient follows the same shift pulses (RQ8, RQ20)
    quot_down         = shift_right_in | shift_left_in;
    quot_main_rst_src = '1;
    if (shift_right_in) begin
      quot_main_rst_src = {state_reg.acc_stg[`SARD_LSB_BIT],
                           state_reg.quot_stg[0:`SARD_LSB_BIT-1]}; // RQ11
    end
    if (shift_left_in) begin
      quot_main_rst_src = {state_reg.quot_stg[1:`SARD_LSB_BIT],
                           state_reg.acc_stg[`SARD_SIGN_BIT]}; // RQ9
    end
  end

  // ----------------------------------------------------------------
  // clear-then-gate registers
  // ----------------------------------------------------------------
  sard_xfer #(
    .WIDTH (`SARD_WIDTH + 1)
  ) u_acc_stg (
    .cur_in      ({state_reg.acc_ext, state_reg.acc_stg}),
    .clr_zero_in (clr_stg_zero_in), // RQ4 RQ15
    .clr_one_in  (1'b0),
    .set_en_in   (copy_up_in | gate_sum_in), // RQ3
    .set_src_in  (acc_stg_set_src),
    .rst_en_in   (1'b0),
    .rst_src_in  ({(`SARD_WIDTH + 1){1'b1}}),
    .nxt_out     (acc_stg_nxt)
  );

  sard_xfer #(
    .WIDTH (`SARD_WIDTH)
  ) u_acc_main (
    .cur_in      (state_reg.acc_main),
    .clr_zero_in (1'b0),
    .clr_one_in  (clr_main_one_in), // RQ4
    .set_en_in   (1'b0),
    .set_src_in  ('0),
    .rst_en_in   (acc_down), // RQ3
    .rst_src_in  (acc_main_rst_src),
    .nxt_out     (acc_main_nxt)
  );

  sard_xfer #(
    .WIDTH (`SARD_WIDTH)
  ) u_quot_stg (
    .cur_in      (state_reg.quot_stg),
    .clr_zero_in (clr_stg_zero_in), // RQ20
    .clr_one_in  (1'b0),
    .set_en_in   (copy_up_in), // RQ2 RQ20
    .set_src_in  (state_reg.quot_main),
    .rst_en_in   (1'b0),
    .rst_src_in  ('1),
    .nxt_out     (quot_stg_nxt)
  );

  sard_xfer #(
    .WIDTH (`SARD_WIDTH)
  ) u_quot_main (
    .cur_in      (state_reg.quot_main),
    .clr_zero_in (1'b0),
    .clr_one_in  (clr_main_one_in), // RQ20
    .set_en_in   (1'b0),
    .set_src_in  ('0),
    .rst_en_in   (quot_down), // RQ8
    .rst_src_in  (quot_main_rst_src),
    .nxt_out     (quot_main_nxt)
  );

  sard_xfer #(
    .WIDTH (`SARD_WIDTH)
  ) u_operand (
    .cur_in      (state_reg.operand),
    .clr_zero_in (clr_operand_in), // RQ3
    .clr_one_in  (1'b0),
    .set_en_in   (load_operand_in), // RQ14
    .set_src_in  (mem_word_in),
    .rst_en_in   (1'b0),
    .rst_src_in  ('1),
    .nxt_out     (operand_nxt)
  );

  // ----------------------------------------------------------------
  // next state and registers
  // ----------------------------------------------------------------
  always_comb begin
    state_next           = state_reg;
    state_next.acc_ext   = acc_stg_nxt[0];
    state_next.acc_stg   = acc_stg_nxt[1:`SARD_WIDTH];
    state_next.acc_main  = acc_main_nxt;
    state_next.quot_stg  = quot_stg_nxt;
    state_next.quot_main = quot_main_nxt;
    state_next.operand   = operand_nxt;
    // the gate choice stays until the next gate pulse so the sum is
    // still standing when gate 3 samples it a step later
    if (gate_true_in) begin
      state_next.add_sel = sard_sel_true; // RQ14
    end
    if (gate_compl_in) begin
      state_next.add_sel = sard_sel_compl; // RQ18
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg.acc_ext   <= `SARD_RST_EXT;
      state_reg.acc_stg   <= `SARD_RST_WORD;
      state_reg.acc_main  <= `SARD_RST_WORD;
      state_reg.quot_stg  <= `SARD_RST_WORD;
      state_reg.quot_main <= `SARD_RST_WORD;
      state_reg.operand   <= `SARD_RST_WORD;
      state_reg.add_sel   <= sard_sel_none;
    end else begin
      state_reg <= state_next;
    end
  end

  assign acc_staging_sign_ext_out = state_reg.acc_ext;
  assign acc_staging_out          = state_reg.acc_stg;
  assign acc_main_out             = state_reg.acc_main;
  assign quot_staging_out         = state_reg.quot_stg;
  assign quot_main_out            = state_reg.quot_main;
  assign operand_reg_out          = state_reg.operand;
  assign adder_sel_out            = state_reg.add_sel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sard_word_t chk_true_sum;
  sard_word_t chk_diff;
  assign chk_true_sum = state_reg.acc_main + state_reg.operand;
  assign chk_diff     = state_reg.acc_main - state_reg.operand;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  stg_clear_a: assert property ( // RQ3
    clr_stg_zero_in && !copy_up_in && !gate_sum_in
    |=> state_reg.acc_stg == '0 && !state_reg.acc_ext
  ) else $error("staging not cleared to zeros");

  copy_up_a: assert property ( // RQ2
    clr_stg_zero_in ##1 (copy_up_in && !clr_stg_zero_in)
    |=> state_reg.acc_stg == $past(state_reg.acc_main)
        && state_reg.quot_stg == $past(state_reg.quot_main)
  ) else $error("staging copy of main wrong");

  right_shift_a: assert property ( // RQ4
    shift_right_in && state_reg.acc_main == '1
    |=> state_reg.acc_main[1:39] == $past(state_reg.acc_stg[0:38])
  ) else $error("right shift of accumulator wrong");

  sign_repl_a: assert property ( // RQ12
    clr_stg_zero_in ##1 copy_up_in ##1 clr_main_one_in
    ##1 shift_right_in
    |=> state_reg.acc_main[0] == state_reg.acc_main[1]
  ) else $error("sign not replicated on right shift");

  left_shift_a: assert property ( // RQ10
    shift_left_in && state_reg.acc_main == '1
    |=> state_reg.acc_main == {$past(state_reg.acc_stg[1:39]), 1'b0}
  ) else $error("left shift of accumulator wrong");

  quot_couple_a: assert property ( // RQ8
    shift_right_in && state_reg.quot_main == '1
    |=> state_reg.quot_main[1:39] == $past(state_reg.quot_stg[0:38])
  ) else $error("quotient did not follow right shift");

  right_carry_a: assert property ( // RQ11
    shift_right_in && state_reg.quot_main == '1
    |=> state_reg.quot_main[0] == $past(state_reg.acc_stg[39])
  ) else $error("accumulator low bit lost on right shift");

  left_carry_a: assert property ( // RQ9
    shift_left_in && state_reg.quot_main == '1
    |=> state_reg.quot_main[39] == $past(state_reg.acc_stg[0])
        && state_reg.quot_main[0:38] == $past(state_reg.quot_stg[1:39])
  ) else $error("left shift carry into quotient wrong");

  sum_left_a: assert property ( // RQ16
    gate_sum_in && state_reg.add_sel == sard_sel_true
    && state_reg.acc_stg == '0 && !state_reg.acc_ext
    |=> {state_reg.acc_ext, state_reg.acc_stg}
        == {$past(chk_true_sum), 1'b0}
  ) else $error("sum not loaded left displaced");

  diff_a: assert property ( // RQ18
    gate_sum_in && state_reg.add_sel == sard_sel_compl
    && state_reg.acc_stg == '0 && !state_reg.acc_ext
    |=> {state_reg.acc_ext, state_reg.acc_stg} == {$past(chk_diff), 1'b0}
  ) else $error("difference not formed with carry in");

  sum_home_a: assert property ( // RQ17
    sum_right_in && state_reg.acc_main == '1
    |=> state_reg.acc_main
        == {$past(state_reg.acc_ext), $past(state_reg.acc_stg[0:38])}
  ) else $error("sum not moved back into main");

  operand_load_a: assert property ( // RQ14
    clr_operand_in ##1 (load_operand_in && !clr_operand_in)
    |=> state_reg.operand == $past(mem_word_in)
  ) else $error("operand not loaded from memory word");

endmodule : sard_datapath

`default_nettype wire

// ---- testbench/sard_ctrl_model.sv ----
// control sequencer model issuing clear and gate pulses to the datapath
`default_nettype none

module sard_ctrl_model (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       start_in,
  input  wire logic [1:0] op_in,
  input  wire logic       slow_in,
  output logic            clr_operand_out,
  output logic            load_operand_out,
  output logic            gate_true_out,
  output logic            gate_compl_out,
  output logic            clr_stg_zero_out,
  output logic            copy_up_out,
  output logic            clr_main_one_out,
  output logic            shift_right_out,
  output logic            shift_left_out,
  output logic            gate_sum_out,
  output logic            sum_right_out,
  output logic            done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ops: 0 right shift, 1 left shift, 2 add, 3 subtract
  logic [2:0] step_reg;
  logic [1:0] op_reg;
  logic       ph_reg;
  logic       is_add;
  logic       last;
  logic       act;

  assign is_add = op_reg[1];
  assign act    = !ph_reg;
  assign last   = act && (is_add ? step_reg == 3'd6 : step_reg == 3'd4);

  // -------------------------------------------------------------
  // step sequencing
  // -------------------------------------------------------------
  // slow mode idles every other cycle so the datapath must hold its state
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      step_reg <= #1 3'd0;
      op_reg   <= #1 2'd0;
      ph_reg   <= #1 1'b0;
    end else if (step_reg == 3'd0) begin
      ph_reg <= #1 1'b0;
      if (start_in) begin
        step_reg <= #1 3'd1;
        op_reg   <= #1 op_in;
      end
    end else begin
      ph_reg <= #1 slow_in ? ~ph_reg : 1'b0;
      if (last) step_reg <= #1 3'd7;
      else if (act && step_reg == 3'd7) step_reg <= #1 3'd0;
      else if (act) step_reg <= #1 step_reg + 3'd1;
    end
  end

  // -------------------------------------------------------------
  // pulse decode, one pulse per step except gate plus staging clear at add step 3, never two conflicting gates
  // -------------------------------------------------------------
  assign clr_operand_out  = act && is_add && step_reg == 3'd1;
  assign load_operand_out = act && is_add && step_reg == 3'd2;
  assign gate_true_out    = act && op_reg == 2'd2 && step_reg == 3'd3;
  assign gate_compl_out   = act && op_reg == 2'd3 && step_reg == 3'd3;
  assign clr_stg_zero_out = act && (is_add ? step_reg == 3'd3
                                           : step_reg == 3'd1);
  assign copy_up_out      = act && !is_add && step_reg == 3'd2;
  assign clr_main_one_out = act && (is_add ? step_reg == 3'd5
                                           : step_reg == 3'd3);
  assign shift_right_out  = act && op_reg == 2'd0 && step_reg == 3'd4;
  assign shift_left_out   = act && op_reg == 2'd1 && step_reg == 3'd4;
  assign gate_sum_out     = act && is_add && step_reg == 3'd4;
  assign sum_right_out    = act && is_add && step_reg == 3'd6;
  assign done_out         = act && step_reg == 3'd7;
endmodule : sard_ctrl_model

`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the shift and add register datapath
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sard_pkg::*;

  typedef struct packed {
    sard_word_t acc;
    sard_word_t quot;
    sard_word_t op;
    sard_sel_t  sel;
    sard_word_t stg;
    sard_word_t qstg;
    logic       ext;
  } sard_exp_t;

  logic       clock_in;
  logic       sys_rst_in;
  sard_word_t mem_word_in;
  logic       start;
  logic [1:0] op;
  logic       slow;
  logic       clr_op, ld_op, g_true, g_compl, clr_stg, cp_up, clr_one;
  logic       sh_r, sh_l, g_sum, s_right, done;
  logic       ext;
  sard_word_t acc_stg, acc_main, quot_stg, quot_main, opnd;
  sard_sel_t  sel;
  sard_exp_t  exp_q[$];
  int         err_count = 0;
  int         compares = 0;
  integer     seed = 32'hdf4c;

  sard_ctrl_model sard_ctrl_model_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .start_in(start),
    .op_in(op), .slow_in(slow), .clr_operand_out(clr_op),
    .load_operand_out(ld_op), .gate_true_out(g_true),
    .gate_compl_out(g_compl), .clr_stg_zero_out(clr_stg),
    .copy_up_out(cp_up), .clr_main_one_out(clr_one),
    .shift_right_out(sh_r), .shift_left_out(sh_l),
    .gate_sum_out(g_sum), .sum_right_out(s_right), .done_out(done));

  sard_datapath sard_datapath_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .mem_word_in(mem_word_in),
    .clr_operand_in(clr_op), .load_operand_in(ld_op),
    .gate_true_in(g_true), .gate_compl_in(g_compl),
    .clr_stg_zero_in(clr_stg), .copy_up_in(cp_up),
    .clr_main_one_in(clr_one), .shift_right_in(sh_r),
    .shift_left_in(sh_l), .gate_sum_in(g_sum), .sum_right_in(s_right),
    .acc_staging_sign_ext_out(ext), .acc_staging_out(acc_stg),
    .acc_main_out(acc_main), .quot_staging_out(quot_stg),
    .quot_main_out(quot_main), .operand_reg_out(opnd),
    .adder_sel_out(sel));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // -------------------------------------------------------------
  // comparison and closing
  // -------------------------------------------------------------
  task automatic check(input string name, input logic [0:39] seen,
                       input logic [0:39] expv);
    compares++;
    if (seen !== expv) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // results appear when the sequencer reports the last pulse taken
  always @(posedge clock_in) begin
    sard_exp_t e;
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR queue expected note seen none");
      end else begin
        e = exp_q.pop_front();
        check("acc_main", acc_main, e.acc);
        check("quot_main", quot_main, e.quot);
        check("operand_reg", opnd, e.op);
        check("adder_sel", {37'h0, sel}, {37'h0, e.sel});
        check("acc_staging", acc_stg, e.stg);
        check("quot_staging", quot_stg, e.qstg);
        check("acc_staging_sign_ext", {39'h0, ext}, {39'h0, e.ext});
      end
    end
  end

  // -------------------------------------------------------------
  // main sequence: directed opening, then random operations
  // -------------------------------------------------------------
  initial begin
    sard_word_t m_acc, m_quot, m_op, q, mem;
    sard_word_t m_stg, m_qstg;
    logic       m_ext;
    sard_sel_t  m_sel;
    int         kind;
    int         w;
    sys_rst_in  = 1'b1;
    mem_word_in = '0;
    start       = 1'b0;
    op          = 2'd0;
    slow        = 1'b0;
    m_acc       = '0;
    m_quot      = '0;
    m_op        = '0;
    m_sel       = sard_sel_none;
    repeat (5) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    for (int i = 0; i < 60; i++) begin
      if (i == 30) begin
        // mid-run reset: every register to zero, gate choice to none
        #1 sys_rst_in = 1'b1;
        repeat (2) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        check("acc_main", acc_main, '0);
        check("quot_main", quot_main, '0);
        check("operand_reg", opnd, '0);
        check("acc_staging", acc_stg, '0);
        check("adder_sel", {37'h0, sel}, {37'h0, sard_sel_none});
        m_acc  = '0;
        m_quot = '0;
        m_op   = '0;
        m_sel  = sard_sel_none;
      end
      // negative word with a low one exercises sign and end carries first
      kind = (i < 4) ? ((i == 0) ? 2 : (i == 3) ? 3 : i - 1)
                     : ($random(seed) & 3);
      mem  = (i == 0) ? 40'h80_0000_0001
                      : sard_word_t'({$random(seed), $random(seed)});
      // shifts leave the old mains standing in the staging registers
      m_stg  = m_acc;
      m_ext  = m_acc[0];
      m_qstg = m_quot;
      case (kind)
        0: begin
          q      = {m_acc[39], m_quot[0:38]};
          m_acc  = {m_acc[0], m_acc[0:38]};
          m_quot = q;
        end
        1: begin
          m_quot = {m_quot[1:39], m_acc[0]};
          m_acc  = {m_acc[1:39], 1'b0};
        end
        default: begin
          m_op   = mem;
          m_acc  = (kind == 2) ? m_acc + mem : m_acc - mem;
          m_quot = '1;
          m_sel  = (kind == 2) ? sard_sel_true : sard_sel_compl;
          m_ext  = m_acc[0];
          m_stg  = {m_acc[1:39], 1'b0};
          m_qstg = '0;
        end
      endcase
      exp_q.push_back('{m_acc, m_quot, m_op, m_sel, m_stg, m_qstg, m_ext});
      @(posedge clock_in);
      #1;
      start       = 1'b1;
      op          = kind[1:0];
      mem_word_in = mem;
      slow        = (i > 3) ? 1'($random(seed)) : 1'b0;
      @(posedge clock_in);
      #1 start = 1'b0;
      w = 0;
      while (done !== 1'b1 && w < 40) begin
        @(posedge clock_in);
        w++;
      end
      if (done !== 1'b1) begin
        err_count++;
        $display("ERROR done expected 1 seen timeout");
        break;
      end
    end
    repeat (2) @(posedge clock_in);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
